// >>> hw/ioc_pkg.sv
package ioc_pkg;
    // clock and strobe timing
    localparam int IOC_CLK_MHZ = 100;
    localparam int IOC_STROBE_NS = 30;
    localparam int IOC_STROBE_CYC = (IOC_STROBE_NS * IOC_CLK_MHZ + 999) / 1000;
    localparam logic [3:0] IOC_STROBE_LAST = 4'(IOC_STROBE_CYC - 1);
    // I/O ports seen by the controller
    localparam logic [9:0] IOC_PORT_CMD = 10'h020;
    localparam logic [9:0] IOC_PORT_DATA = 10'h021;
    localparam logic [9:0] IOC_PORT_VEC = 10'h063;
    localparam logic [9:0] IOC_PORT_DIAG = 10'h069;
    localparam logic [9:0] IOC_PORT_RTC_STAT = 10'h0B0;
    // command word fields
    localparam int IOC_IC4_BIT = 0;
    localparam int IOC_SNGL_BIT = 1;
    localparam int IOC_SEL_BIT = 3;
    localparam int IOC_INIT_BIT = 4;
    localparam int IOC_EOI_BIT = 5;
    localparam int IOC_SPEC_BIT = 6;
    localparam int IOC_RR_BIT = 1;
    localparam int IOC_RIS_BIT = 0;
    // diagnostic port fields and forcing port fields
    localparam int IOC_DIAG_NMI_BIT = 2;
    localparam int IOC_DIAG_VRD_BIT = 6;
    localparam int IOC_DIAG_FORCE_BIT = 7;
    localparam int IOC_FORCE_NMI_BIT = 0;
    // fixed values
    localparam logic [7:0] IOC_IRQ1_VECTOR = 8'h71;
    localparam logic [7:0] IOC_RST_BYTE = 8'h00;
    localparam logic [7:0] IOC_IDLE_BUS = 8'hFF;
    // host register word indices and operations
    localparam logic [1:0] IOC_HREG_ADDR = 2'h0;
    localparam logic [1:0] IOC_HREG_WDATA = 2'h1;
    localparam logic [1:0] IOC_HREG_CTRL = 2'h2;
    localparam logic [1:0] IOC_HREG_STATUS = 2'h3;
    localparam logic [1:0] IOC_OP_WR = 2'h1;
    localparam logic [1:0] IOC_OP_RD = 2'h2;
    localparam logic [1:0] IOC_OP_ACK = 2'h3;
    typedef enum logic [3:0] {
        IOC_ST_OPER = 4'b0001,
        IOC_ST_W2 = 4'b0010,
        IOC_ST_W3 = 4'b0100,
        IOC_ST_W4 = 4'b1000
    } ioc_init_type;
    typedef enum logic [2:0] {
        IOC_HS_IDLE = 3'b001,
        IOC_HS_STROBE = 3'b010,
        IOC_HS_GAP = 3'b100
    } ioc_host_type;
endpackage

// >>> hw/ioc_link.sv
`timescale 1ns/1ns
`default_nettype none
interface ioc_link;
    logic [9:0] io_addr;
    logic io_rd_n;
    logic io_wr_n;
    logic ack_strobe_n;
    logic [7:0] host_data;
    logic host_oe;
    logic [7:0] dev_data;
    logic dev_oe;
    logic [7:0] data_bus;
    logic cpu_int_request;
    logic nmi_request;
    // resolved data bus: device wins, else host, else pulled high
    assign data_bus = dev_oe ? dev_data : (host_oe ? host_data : 8'hFF);
    modport dev (
        input io_addr, io_rd_n, io_wr_n, ack_strobe_n, data_bus,
        output dev_data, dev_oe, cpu_int_request, nmi_request
    );
    modport host (
        input data_bus, cpu_int_request, nmi_request,
        output io_addr, io_rd_n, io_wr_n, ack_strobe_n, host_data, host_oe
    );
endinterface
`default_nettype wire

// >>> hw/ioc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ioc_sync #(
    parameter int WIDTH = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    // two stages; the first one is read only by the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// >>> hw/ioc_device.sv
// Functional notes
// - eight levels, highest unmasked pending wins
// - timer channel 0 drives level 0 only
// - level 1 merges clock and keyboard
// - init words at 0020, then 0021 sequence
// - operation writes: mask, eoi, read select
// - reads: mask, or pending/in-service by select
// - 020h write with bit4 starts init
// - vector base also copied to readback
// - readback at vector_readback needs diag bit6
// - readback clears at reset
// - 63h forces levels 7..2 and nmi
// - forcing needs diag bit7 set first
// - nmi forcing needs diag bit2
// - level 1 acknowledge yields vector 71h
// - acknowledge answered with one wait state
// - reading B0h clears clock interrupt
// - levels 2..7 take channel and serial/parallel
// - external requests synchronised first
// - request output follows unmasked pending not blocked by in-service, outside init only
// - two low acknowledge pulses from processor
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ioc_device (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // processor side
    ioc_link.dev lnk,
    // on-chip sources
    input wire logic timer0_out,
    input wire logic rtc_int,
    input wire logic kbd_int,
    input wire logic ser1_int,
    input wire logic ser2_int,
    input wire logic par_int,
    // expansion channel request pins, asynchronous
    input wire logic [7:2] irq_pin
);
    import ioc_pkg::*;

    // lowest set index wins; bit 7 reported when none set
    function automatic logic [3:0] pick(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h7;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    ioc_init_type state_reg;
    logic [7:0] mask_register;
    logic [7:0] in_service_register;
    logic [7:0] vec_base_reg;
    logic [7:0] vec_rb_reg;
    logic [7:0] diag_reg;
    logic [7:0] force_reg;
    logic sngl_reg;
    logic ic4_reg;
    logic read_isr_reg;
    logic rtc_pend_reg;
    logic wr_d_reg;
    logic rd_d_reg;
    logic ack_d_reg;
    logic ack_second_reg;
    logic [2:0] ack_level_reg;
    logic [7:0] dev_data_reg;
    logic dev_oe_reg;
    logic int_reg;
    logic [7:2] irq_s;
    logic [7:0] pending_request_register;
    logic [7:0] eligible;
    logic [3:0] top_req;
    logic [3:0] top_isr;
    logic wr_fall;
    logic rd_fall;
    logic ack_fall;
    logic wr_cmd;
    logic wr_data;
    logic [7:0] wd;

    ioc_sync #(.WIDTH(6)) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in(irq_pin),
        .sync_out(irq_s)
    );

    // strobe edges; the host runs on this clock so no synchroniser
    assign wr_fall = !lnk.io_wr_n && wr_d_reg;
    assign rd_fall = !lnk.io_rd_n && rd_d_reg;
    assign ack_fall = !lnk.ack_strobe_n && ack_d_reg;
    assign wr_cmd = wr_fall && lnk.io_addr == IOC_PORT_CMD;
    assign wr_data = wr_fall && lnk.io_addr == IOC_PORT_DATA;
    assign wd = lnk.data_bus;

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_d_reg <= 1'b1;
            rd_d_reg <= 1'b1;
            ack_d_reg <= 1'b1;
        end else begin
            wr_d_reg <= lnk.io_wr_n;
            rd_d_reg <= lnk.io_rd_n;
            ack_d_reg <= lnk.ack_strobe_n;
        end
    end

    // request levels: 0 timer, 1 shared, 2..7 channel plus on-chip ports and forcing
    assign pending_request_register = {
        irq_s[7] | par_int | force_reg[7],
        irq_s[6] | force_reg[6],
        irq_s[5] | force_reg[5],
        irq_s[4] | ser1_int | force_reg[4],
        irq_s[3] | ser2_int | force_reg[3],
        irq_s[2] | force_reg[2],
        rtc_pend_reg | kbd_int,
        timer0_out
    };

    // only levels above the highest in service may compete
    assign top_isr = pick(in_service_register);
    always_comb begin
        eligible = pending_request_register & ~mask_register;
        for (int i = 0; i < 8; i++) begin
            if (top_isr[3] && 3'(i) >= top_isr[2:0]) begin
                eligible[i] = 1'b0;
            end
        end
    end
    assign top_req = pick(eligible);

    // clock interrupt latch; a new event beats the clearing read
    always_ff @(posedge clk) begin
        if (rst) begin
            rtc_pend_reg <= 1'b0;
        end else if (rtc_int) begin
            rtc_pend_reg <= 1'b1;
        end else if (rd_fall && lnk.io_addr == IOC_PORT_RTC_STAT) begin
            rtc_pend_reg <= 1'b0;
        end
    end

    // diagnostic port gates readback and forcing
    always_ff @(posedge clk) begin
        if (rst) begin
            diag_reg <= IOC_RST_BYTE;
        end else if (wr_fall && lnk.io_addr == IOC_PORT_DIAG) begin
            diag_reg <= wd;
        end
    end

    // forced levels are sticky until rewritten, unlike a pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            force_reg <= IOC_RST_BYTE;
        end else if (wr_fall && lnk.io_addr == IOC_PORT_VEC && diag_reg[IOC_DIAG_FORCE_BIT]) begin
            force_reg[7:2] <= wd[7:2];
            if (diag_reg[IOC_DIAG_NMI_BIT]) begin
                force_reg[IOC_FORCE_NMI_BIT] <= wd[IOC_FORCE_NMI_BIT];
            end
        end
    end

    // initialisation sequence and operation-mode control words
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= IOC_ST_OPER;
            mask_register <= IOC_RST_BYTE;
            vec_base_reg <= IOC_RST_BYTE;
            vec_rb_reg <= IOC_RST_BYTE;
            sngl_reg <= 1'b1;
            ic4_reg <= 1'b0;
            read_isr_reg <= 1'b0;
        end else if (wr_cmd && wd[IOC_INIT_BIT]) begin
            state_reg <= IOC_ST_W2;
            mask_register <= IOC_RST_BYTE;
            sngl_reg <= wd[IOC_SNGL_BIT];
            ic4_reg <= wd[IOC_IC4_BIT];
            read_isr_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                IOC_ST_W2: begin
                    if (wr_data) begin
                        vec_base_reg <= wd;
                        vec_rb_reg <= wd;
                        state_reg <= !sngl_reg ? IOC_ST_W3 : (ic4_reg ? IOC_ST_W4 : IOC_ST_OPER);
                    end
                end
                IOC_ST_W3: begin
                    if (wr_data) begin
                        state_reg <= ic4_reg ? IOC_ST_W4 : IOC_ST_OPER; // cascade word not used
                    end
                end
                IOC_ST_W4: begin
                    if (wr_data) begin
                        state_reg <= IOC_ST_OPER;
                    end
                end
                IOC_ST_OPER: begin
                    if (wr_data) begin
                        mask_register <= wd;
                    end
                    if (wr_cmd && wd[IOC_SEL_BIT] && wd[IOC_RR_BIT]) begin
                        read_isr_reg <= wd[IOC_RIS_BIT];
                    end
                end
            endcase
        end
    end

    // acknowledge pairs: first pulse freezes the level, second returns the vector
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_second_reg <= 1'b0;
            ack_level_reg <= 3'h7;
        end else if (ack_fall) begin
            ack_second_reg <= !ack_second_reg;
            if (!ack_second_reg) begin
                ack_level_reg <= top_req[2:0];
            end
        end
    end

    // in-service bits: set on second acknowledge, cleared by end-of-interrupt
    always_ff @(posedge clk) begin
        if (rst) begin
            in_service_register <= IOC_RST_BYTE;
        end else if (wr_cmd && wd[IOC_INIT_BIT]) begin
            in_service_register <= IOC_RST_BYTE;
        end else if (ack_fall && ack_second_reg) begin
            in_service_register[ack_level_reg] <= 1'b1;
        end else if (wr_cmd && state_reg == IOC_ST_OPER && !wd[IOC_SEL_BIT] && wd[IOC_EOI_BIT]) begin
            if (wd[IOC_SPEC_BIT]) begin
                in_service_register[wd[2:0]] <= 1'b0;
            end else if (top_isr[3]) begin
                in_service_register[top_isr[2:0]] <= 1'b0;
            end
        end
    end

    // read answers, registered one cycle after the strobe falls
    always_ff @(posedge clk) begin
        if (rst) begin
            dev_data_reg <= IOC_RST_BYTE;
            dev_oe_reg <= 1'b0;
        end else if (ack_fall && ack_second_reg) begin
            dev_oe_reg <= 1'b1;
            if (ack_level_reg == 3'h1) begin
                dev_data_reg <= IOC_IRQ1_VECTOR;
            end else begin
                dev_data_reg <= {vec_base_reg[7:3], ack_level_reg};
            end
        end else if (rd_fall) begin
            dev_oe_reg <= 1'b1;
            unique case (lnk.io_addr)
                IOC_PORT_DATA: dev_data_reg <= mask_register;
                IOC_PORT_CMD: dev_data_reg <= read_isr_reg ? in_service_register : pending_request_register;
                IOC_PORT_DIAG: dev_data_reg <= diag_reg;
                IOC_PORT_RTC_STAT: dev_data_reg <= {7'h00, rtc_pend_reg};
                IOC_PORT_VEC: begin
                    // without the enable the port stays off the bus
                    dev_oe_reg <= diag_reg[IOC_DIAG_VRD_BIT];
                    dev_data_reg <= vec_rb_reg;
                end
                default: dev_oe_reg <= 1'b0;
            endcase
        end else if (lnk.io_rd_n && lnk.ack_strobe_n) begin
            dev_oe_reg <= 1'b0;
        end
    end

    // request output only outside initialisation
    always_ff @(posedge clk) begin
        if (rst) begin
            int_reg <= 1'b0;
        end else begin
            int_reg <= state_reg == IOC_ST_OPER && top_req[3];
        end
    end

    assign lnk.dev_data = dev_data_reg;
    assign lnk.dev_oe = dev_oe_reg;
    assign lnk.cpu_int_request = int_reg;
    assign lnk.nmi_request = force_reg[IOC_FORCE_NMI_BIT];
endmodule
`default_nettype wire

// >>> hw/ioc_host.sv
`timescale 1ns/1ns
`default_nettype none
module ioc_host (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // device side
    ioc_link.host lnk
);
    import ioc_pkg::*;

    ioc_host_type state_reg;
    logic [9:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic [1:0] op_reg;
    logic [3:0] cnt_reg;
    logic second_reg;
    logic rd_n_reg;
    logic wr_n_reg;
    logic ack_n_reg;
    logic oe_reg;
    logic busy;
    logic take;

    assign busy = state_reg != IOC_HS_IDLE;
    // a bus access is taken at the edge where waitrequest is seen low
    assign take = (avs_read || avs_write) && !avs_waitrequest;

    // one wait cycle per access, then waitrequest rises again
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            unique case (avs_address)
                IOC_HREG_ADDR: avs_readdata <= {22'h000000, addr_reg};
                IOC_HREG_WDATA: avs_readdata <= {24'h000000, wdata_reg};
                IOC_HREG_CTRL: avs_readdata <= {30'h00000000, op_reg};
                IOC_HREG_STATUS: avs_readdata <= {14'h0000, lnk.nmi_request, lnk.cpu_int_request,
                                                  rdata_reg, 7'h00, busy};
            endcase
        end
    end

    // software orders; writes to any order register while busy are dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_reg <= 10'h000;
            wdata_reg <= IOC_RST_BYTE;
        end else if (take && avs_write && !busy) begin
            if (avs_address == IOC_HREG_ADDR) begin
                addr_reg <= avs_writedata[9:0];
            end
            if (avs_address == IOC_HREG_WDATA) begin
                wdata_reg <= avs_writedata[7:0];
            end
        end
    end

    // cycle sequencer; port order for init and forcing is left to software
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= IOC_HS_IDLE;
            op_reg <= 2'h0;
            cnt_reg <= 4'h0;
            second_reg <= 1'b0;
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            ack_n_reg <= 1'b1;
            oe_reg <= 1'b0;
            rdata_reg <= IOC_RST_BYTE;
        end else begin
            unique case (state_reg)
                IOC_HS_IDLE: begin
                    if (take && avs_write && avs_address == IOC_HREG_CTRL && avs_writedata[1:0] != 2'h0) begin
                        op_reg <= avs_writedata[1:0];
                        cnt_reg <= IOC_STROBE_LAST;
                        second_reg <= 1'b0;
                        state_reg <= IOC_HS_STROBE;
                        wr_n_reg <= avs_writedata[1:0] != IOC_OP_WR;
                        oe_reg <= avs_writedata[1:0] == IOC_OP_WR;
                        rd_n_reg <= avs_writedata[1:0] != IOC_OP_RD;
                        ack_n_reg <= avs_writedata[1:0] != IOC_OP_ACK;
                    end
                end
                IOC_HS_STROBE: begin
                    if (cnt_reg == 4'h0) begin
                        if (op_reg != IOC_OP_WR) begin
                            rdata_reg <= lnk.data_bus;
                        end
                        rd_n_reg <= 1'b1;
                        wr_n_reg <= 1'b1;
                        ack_n_reg <= 1'b1;
                        oe_reg <= 1'b0;
                        state_reg <= IOC_HS_GAP;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                IOC_HS_GAP: begin
                    // acknowledge is always a pair of pulses
                    if (op_reg == IOC_OP_ACK && !second_reg) begin
                        second_reg <= 1'b1;
                        cnt_reg <= IOC_STROBE_LAST;
                        ack_n_reg <= 1'b0;
                        state_reg <= IOC_HS_STROBE;
                    end else begin
                        op_reg <= 2'h0;
                        state_reg <= IOC_HS_IDLE;
                    end
                end
                default: state_reg <= IOC_HS_IDLE;
            endcase
        end
    end

    assign lnk.io_addr = addr_reg;
    assign lnk.host_data = wdata_reg;
    assign lnk.host_oe = oe_reg;
    assign lnk.io_rd_n = rd_n_reg;
    assign lnk.io_wr_n = wr_n_reg;
    assign lnk.ack_strobe_n = ack_n_reg;
endmodule
`default_nettype wire

// >>> testbench/ioc_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ioc_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link signals
    input wire logic [9:0] io_addr,
    input wire logic io_rd_n,
    input wire logic io_wr_n,
    input wire logic ack_strobe_n,
    input wire logic [7:0] data_bus,
    input wire logic dev_oe,
    input wire logic cpu_int_request,
    input wire logic nmi_request
);
    import ioc_pkg::*;
    logic [7:0] diag_reg;
    logic ack_odd_reg;
    // shadow of the diagnostic port, since the gating checks need its enables
    always_ff @(posedge clk) begin
        if (rst) begin
            diag_reg <= 8'h00;
        end else if ($fell(io_wr_n) && io_addr == IOC_PORT_DIAG) begin
            diag_reg <= data_bus;
        end
    end
    // acknowledge pulses come in pairs; set means the next one is the second
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_odd_reg <= 1'b0;
        end else if ($fell(ack_strobe_n)) begin
            ack_odd_reg <= !ack_odd_reg;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_wr_width; $fell(io_wr_n) |=> !io_wr_n ##1 !io_wr_n ##1 io_wr_n; endproperty
    a_wr_width: assert property (p_wr_width) else $error("write strobe width wrong");
    property p_ack_width; $fell(ack_strobe_n) |-> !ack_strobe_n [*3] ##1 ack_strobe_n; endproperty
    a_ack_width: assert property (p_ack_width) else $error("ack pulse width wrong");
    property p_rd_answer; $fell(io_rd_n) && io_addr == IOC_PORT_DATA |=> dev_oe [*2]; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("mask read not driven");
    property p_vec_deny; $fell(io_rd_n) && io_addr == IOC_PORT_VEC && !diag_reg[6] |=> !dev_oe [*3]; endproperty
    a_vec_deny: assert property (p_vec_deny) else $error("readback driven while disabled");
    property p_vec_grant; $fell(io_rd_n) && io_addr == IOC_PORT_VEC && diag_reg[6] |=> dev_oe; endproperty
    a_vec_grant: assert property (p_vec_grant) else $error("readback not driven");
    property p_ack_first; $fell(ack_strobe_n) && !ack_odd_reg |=> !dev_oe [*3]; endproperty
    a_ack_first: assert property (p_ack_first) else $error("bus driven on first ack");
    property p_ack_second; $fell(ack_strobe_n) && ack_odd_reg |=> dev_oe; endproperty
    a_ack_second: assert property (p_ack_second) else $error("vector late on second ack");
    property p_oe_release; dev_oe && io_rd_n && ack_strobe_n |=> !dev_oe; endproperty
    a_oe_release: assert property (p_oe_release) else $error("bus held after strobes");
    property p_nmi_gate;
        $rose(nmi_request) |-> $past(io_addr == IOC_PORT_VEC && !io_wr_n) && diag_reg[7] && diag_reg[2];
    endproperty
    a_nmi_gate: assert property (p_nmi_gate) else $error("nmi raised without enabled force");
    property p_init_quiet;
        $fell(io_wr_n) && io_addr == IOC_PORT_CMD && data_bus[IOC_INIT_BIT] |-> ##2 !cpu_int_request [*2];
    endproperty
    a_init_quiet: assert property (p_init_quiet) else $error("request during init");
    // main scenarios
    c_nmi: cover property ($rose(nmi_request));
    c_int: cover property ($rose(cpu_int_request));
    c_vec: cover property ($fell(ack_strobe_n) && ack_odd_reg);
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import ioc_pkg::*;
    localparam logic [7:0] BASE = 8'hA8;
    logic clk;
    logic rst;
    logic timer0_out, rtc_int, kbd_int, ser1_int, ser2_int, par_int;
    logic [7:2] irq_pin;
    logic [1:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, st;
    int error_cnt;
    int num_checks;
    ioc_link lnk();
    ioc_device ioc_device_inst (.clk(clk), .rst(rst), .lnk(lnk.dev), .timer0_out(timer0_out), .rtc_int(rtc_int),
        .kbd_int(kbd_int), .ser1_int(ser1_int), .ser2_int(ser2_int), .par_int(par_int), .irq_pin(irq_pin));
    ioc_host ioc_host_inst (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .lnk(lnk.host));
    ioc_chk ioc_chk_inst (.clk(clk), .rst(rst), .io_addr(lnk.io_addr), .io_rd_n(lnk.io_rd_n),
        .io_wr_n(lnk.io_wr_n), .ack_strobe_n(lnk.ack_strobe_n), .data_bus(lnk.data_bus), .dev_oe(lnk.dev_oe),
        .cpu_int_request(lnk.cpu_int_request), .nmi_request(lnk.nmi_request));
    // 100 MHz clock
    always #5 clk = ~clk;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one avalon access; an idle edge after release keeps strobes from being reassigned in one step
    task automatic av(input logic [1:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) begin
            error_cnt++;
        end
        if (!wr) begin
            st = avs_readdata;
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    // one link cycle through the host registers, then poll until idle
    task automatic io(input logic [1:0] op, input logic [9:0] a, input logic [7:0] d);
        int n;
        n = 0;
        av(IOC_HREG_ADDR, 1'b1, {22'h0, a});
        av(IOC_HREG_WDATA, 1'b1, {24'h0, d});
        av(IOC_HREG_CTRL, 1'b1, {30'h0, op});
        do begin
            av(IOC_HREG_STATUS, 1'b0, 32'h0);
            n++;
        end while (st[0] !== 1'b0 && n < 50);
        if (n >= 50) begin
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        io(IOC_OP_WR, a, d);
    endtask
    task automatic rd(input logic [9:0] a);
        io(IOC_OP_RD, a, 8'h00);
    endtask
    task automatic ack();
        io(IOC_OP_ACK, 10'h000, 8'h00);
    endtask
    // request sources indexed by their level
    task automatic src(input int k, input logic v);
        case (k)
            0: timer0_out <= v;
            1: kbd_int <= v;
            2: irq_pin[2] <= v;
            3: ser2_int <= v;
            4: ser1_int <= v;
            5: irq_pin[5] <= v;
            6: irq_pin[6] <= v;
            default: par_int <= v;
        endcase
    endtask
    task results();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog, far beyond the roughly one thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end
    // main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {timer0_out, rtc_int, kbd_int, ser1_int, ser2_int, par_int} = 6'h00;
        irq_pin = 6'h00;
        {avs_address, avs_read, avs_write, avs_writedata} = 36'h0;
        error_cnt = 0;
        num_checks = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(IOC_PORT_VEC);
        chk("vec_off", 8'hFF, st[15:8]);
        wr(IOC_PORT_DIAG, 8'hC4);
        rd(IOC_PORT_VEC);
        chk("vec_rst", 8'h00, st[15:8]);
        wr(IOC_PORT_CMD, 8'h13);
        wr(IOC_PORT_DATA, BASE);
        wr(IOC_PORT_DATA, 8'h01);
        rd(IOC_PORT_VEC);
        chk("vec_base", BASE, st[15:8]);
        wr(IOC_PORT_DATA, 8'hFF);
        rd(IOC_PORT_DATA);
        chk("mask", 8'hFF, st[15:8]);
        wr(IOC_PORT_VEC, 8'h05);
        chk("nmi_on", 8'h01, {7'h00, st[17]});
        wr(IOC_PORT_CMD, 8'h0A);
        rd(IOC_PORT_CMD);
        chk("irr", 8'h04, st[15:8]);
        chk("int_masked", 8'h00, {7'h00, st[16]});
        wr(IOC_PORT_DATA, 8'hFB);
        rd(IOC_PORT_DATA);
        chk("int_open", 8'h01, {7'h00, st[16]});
        ack();
        chk("vec_l2", {BASE[7:3], 3'h2}, st[15:8]);
        wr(IOC_PORT_CMD, 8'h0B);
        rd(IOC_PORT_CMD);
        chk("isr", 8'h04, st[15:8]);
        wr(IOC_PORT_VEC, 8'h01);
        wr(IOC_PORT_CMD, 8'h20);
        rd(IOC_PORT_CMD);
        chk("isr_eoi", 8'h00, st[15:8]);
        wr(IOC_PORT_CMD, 8'h0A);
        // forcing refused without its enables
        wr(IOC_PORT_DIAG, 8'h04);
        wr(IOC_PORT_VEC, 8'h80);
        rd(IOC_PORT_CMD);
        chk("irr_locked", 8'h00, st[15:8]);
        wr(IOC_PORT_DIAG, 8'h80);
        wr(IOC_PORT_VEC, 8'h00);
        chk("nmi_kept", 8'h01, {7'h00, st[17]});
        wr(IOC_PORT_DIAG, 8'hC4);
        wr(IOC_PORT_VEC, 8'h00);
        chk("nmi_off", 8'h00, {7'h00, st[17]});
        // each source on its own level, vector per level
        wr(IOC_PORT_DATA, 8'h00);
        for (int k = 0; k < 8; k++) begin
            src(k, 1'b1);
            repeat (4) @(posedge clk);
            ack();
            chk("vec_lvl", (k == 1) ? IOC_IRQ1_VECTOR : {BASE[7:3], 3'(k)}, st[15:8]);
            src(k, 1'b0);
            wr(IOC_PORT_CMD, 8'h20);
        end
        // level 0 beats level 7
        src(0, 1'b1);
        src(7, 1'b1);
        repeat (4) @(posedge clk);
        ack();
        chk("vec_prio", BASE, st[15:8]);
        src(0, 1'b0);
        src(7, 1'b0);
        wr(IOC_PORT_CMD, 8'h20);
        // expansion pins
        for (int k = 2; k < 8; k++) begin
            irq_pin[k] <= 1'b1;
            repeat (4) @(posedge clk);
            ack();
            chk("vec_pin", {BASE[7:3], 3'(k)}, st[15:8]);
            irq_pin[k] <= 1'b0;
            wr(IOC_PORT_CMD, 8'h20);
        end
        // clock interrupt pulse is latched until its status is read
        rtc_int <= 1'b1;
        @(posedge clk);
        rtc_int <= 1'b0;
        ack();
        chk("vec_rtc", IOC_IRQ1_VECTOR, st[15:8]);
        rd(IOC_PORT_RTC_STAT);
        chk("rtc_stat", 8'h01, st[15:8]);
        rd(IOC_PORT_RTC_STAT);
        chk("rtc_clr", 8'h00, st[15:8]);
        wr(IOC_PORT_CMD, 8'h20);
        // re-init drops request
        src(0, 1'b1);
        wr(IOC_PORT_CMD, 8'h13);
        chk("int_init", 8'h00, {7'h00, st[16]});
        results();
    end
endmodule
`default_nettype wire
